// file: pkg/dcseq_consts.vh
// register map, field positions, defaults and timing for dcseq
`ifndef DCSEQ_CONSTS_VH
`define DCSEQ_CONSTS_VH
// register indices, byte address is four times the index
`define DCSEQ_IDX_BOOST_CTRL 8'hc0
`define DCSEQ_IDX_BOOST_TMO 8'hc1
`define DCSEQ_IDX_CONV6_CTRL 8'hc3
`define DCSEQ_IDX_CONV6_TMO 8'hc4
`define DCSEQ_IDX_IRQ_STATUS 8'hc8
`define DCSEQ_IDX_IRQ_MASK 8'hc9
`define DCSEQ_IDX_SEQ_STATUS 8'hca
// implemented bits of the control and timeout registers
`define DCSEQ_MASK_BOOST_CTRL 16'h535b
`define DCSEQ_MASK_TMO 16'hffc0
`define DCSEQ_MASK_CONV6_CTRL 16'hcc7f
// field positions
`define DCSEQ_FB_SRC 1:0
`define DCSEQ_FAULT_ACT 15:14
`define DCSEQ_START_SLOT 13:10
`define DCSEQ_STOP_SLOT 9:6
`define DCSEQ_CAP 15:14
`define DCSEQ_OVP_DIS 11
`define DCSEQ_OUT_FLOAT 10
`define DCSEQ_VCODE 6:0
// field codes
`define DCSEQ_FB_EXT 2'h0
`define DCSEQ_FB_SINK_A 2'h1
`define DCSEQ_FB_SINK_B 2'h2
`define DCSEQ_FB_USB 2'h3
`define DCSEQ_ACT_IGNORE 2'h0
`define DCSEQ_ACT_CONV 2'h1
`define DCSEQ_SLOT_NONE 4'h0
`define DCSEQ_SLOT_EDGE 4'hf
`define DCSEQ_SLOT_LAST 4'he
`define DCSEQ_VCODE_MAX 7'h66
`define DCSEQ_MV_BASE 12'h352
`define DCSEQ_MV_STEP 12'h019
// reset defaults of the converter registers and the interrupt mask
`define DCSEQ_DEF_BOOST_CTRL 16'h0008
`define DCSEQ_DEF_BOOST_TMO 16'h0000
`define DCSEQ_DEF_CONV6_CTRL 16'h0000
`define DCSEQ_DEF_CONV6_TMO 16'h0000
`define DCSEQ_DEF_IRQ_MASK 4'hf
// timing
`define DCSEQ_CLK_MHZ 24'h000032
`define DCSEQ_SLOT_TIME_US 24'h0007d0
`define DCSEQ_SLOT_CYCLES (`DCSEQ_SLOT_TIME_US * `DCSEQ_CLK_MHZ)
`endif

// file: rtl/dcseq_top.v
// power sequencing and fault handling for converters 5 and 6
`timescale 1ns/10ps
`include "dcseq_consts.vh"
module dcseq_top #(
  parameter [23:0] SLOT_CYCLES = `DCSEQ_SLOT_CYCLES,
  parameter [15:0] BOOST_CTRL_DEFAULT = `DCSEQ_DEF_BOOST_CTRL,
  parameter [15:0] BOOST_TMO_DEFAULT = `DCSEQ_DEF_BOOST_TMO,
  parameter [15:0] CONV6_CTRL_DEFAULT = `DCSEQ_DEF_CONV6_CTRL,
  parameter [15:0] CONV6_TMO_DEFAULT = `DCSEQ_DEF_CONV6_TMO
)(
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  input wire power_request,
  input wire boost_fault,
  input wire conv6_fault,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg boost_enable,
  output reg fb_external_divider,
  output reg fb_current_sink_a,
  output reg fb_current_sink_b,
  output reg fb_usb_divider,
  output reg conv6_enable,
  output reg [1:0] conv6_output_capacitance,
  output reg conv6_overvoltage_enable,
  output reg conv6_discharge,
  output reg [6:0] conv6_voltage_code,
  output reg [11:0] conv6_voltage_mv,
  output reg system_shutdown,
  output reg [3:0] current_slot,
  output reg seq_active,
  output reg irq
);

  localparam [3:0] ST_OFF = 4'h1;
  localparam [3:0] ST_UP = 4'h2;
  localparam [3:0] ST_ACTIVE = 4'h4;
  localparam [3:0] ST_DOWN = 4'h8;
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_BC = 3'h1;
  localparam [2:0] SEL_BT = 3'h2;
  localparam [2:0] SEL_CC = 3'h3;
  localparam [2:0] SEL_CT = 3'h4;
  localparam [2:0] SEL_IS = 3'h5;
  localparam [2:0] SEL_IM = 3'h6;
  localparam [2:0] SEL_SS = 3'h7;
  localparam [1:0] RESP_OK = 2'h0;
  localparam [1:0] RESP_ERR = 2'h2;

  reg [15:0] boost_ctrl;
  reg [15:0] boost_tmo;
  reg [15:0] conv6_ctrl;
  reg [15:0] conv6_tmo;
  reg [3:0] irq_status;
  reg [3:0] irq_mask;
  reg [3:0] state;
  reg [23:0] slot_timer;
  reg boost_fault_q;
  reg conv6_fault_q;
  reg boost_tripped;
  reg conv6_tripped;
  reg aw_held;
  reg w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [3:0] next_state;
  reg [3:0] next_slot;
  reg next_boost_en;
  reg next_conv6_en;
  reg [3:0] events;
  reg sys_fault;
  reg [15:0] wr_value;
  reg [15:0] rd_value;
  reg [2:0] wr_sel;
  reg [2:0] rd_sel;
  reg [6:0] vcode_clamped;

  wire boost_fault_rise = boost_fault & ~boost_fault_q;
  wire conv6_fault_rise = conv6_fault & ~conv6_fault_q;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire slot_end = (slot_timer == SLOT_CYCLES - 24'h000001);
  wire [3:0] boost_start = boost_tmo[`DCSEQ_START_SLOT];
  wire [3:0] boost_stop = boost_tmo[`DCSEQ_STOP_SLOT];
  wire [3:0] conv6_start = conv6_tmo[`DCSEQ_START_SLOT];
  wire [3:0] conv6_stop = conv6_tmo[`DCSEQ_STOP_SLOT];

  // address decode shared by the read and write paths
  function [2:0] reg_select;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'h0)
        reg_select = SEL_NONE;
      else if (addr[11:2] == {2'h0, `DCSEQ_IDX_BOOST_CTRL})
        reg_select = SEL_BC;
      else if (addr[11:2] == {2'h0, `DCSEQ_IDX_BOOST_TMO})
        reg_select = SEL_BT;
      else if (addr[11:2] == {2'h0, `DCSEQ_IDX_CONV6_CTRL})
        reg_select = SEL_CC;
      else if (addr[11:2] == {2'h0, `DCSEQ_IDX_CONV6_TMO})
        reg_select = SEL_CT;
      else if (addr[11:2] == {2'h0, `DCSEQ_IDX_IRQ_STATUS})
        reg_select = SEL_IS;
      else if (addr[11:2] == {2'h0, `DCSEQ_IDX_IRQ_MASK})
        reg_select = SEL_IM;
      else if (addr[11:2] == {2'h0, `DCSEQ_IDX_SEQ_STATUS})
        reg_select = SEL_SS;
      else
        reg_select = SEL_NONE;
    end
  endfunction

  // byte-lane merge of a 16-bit register
  function [15:0] lane_merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      lane_merge[7:0] = strb[0] ? data[7:0] : old[7:0];
      lane_merge[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // sequencer next state and converter enables
  always @*
  begin
    next_state = state;
    next_slot = current_slot;
    next_boost_en = boost_enable;
    next_conv6_en = conv6_enable;
    sys_fault = 1'b0;
    if (boost_fault_rise && boost_tmo[`DCSEQ_FAULT_ACT] != `DCSEQ_ACT_IGNORE
        && boost_tmo[`DCSEQ_FAULT_ACT] != `DCSEQ_ACT_CONV)
      sys_fault = 1'b1;
    if (conv6_fault_rise && conv6_tmo[`DCSEQ_FAULT_ACT] != `DCSEQ_ACT_IGNORE
        && conv6_tmo[`DCSEQ_FAULT_ACT] != `DCSEQ_ACT_CONV)
      sys_fault = 1'b1;
    case (state)
      ST_OFF:
      begin
        if (power_request)
        begin
          next_state = ST_UP;
          next_slot = 4'h1;
        end
      end
      ST_UP:
      begin
        if (boost_start == current_slot && !boost_tripped)
          next_boost_en = 1'b1;
        if (conv6_start == current_slot && !conv6_tripped)
          next_conv6_en = 1'b1;
        if (slot_end)
        begin
          if (current_slot == `DCSEQ_SLOT_LAST)
          begin
            next_state = ST_ACTIVE;
            next_slot = 4'h0;
            if (boost_start == `DCSEQ_SLOT_EDGE && !boost_tripped)
              next_boost_en = 1'b1;
            if (conv6_start == `DCSEQ_SLOT_EDGE && !conv6_tripped)
              next_conv6_en = 1'b1;
          end
          else
            next_slot = current_slot + 4'h1;
        end
      end
      ST_ACTIVE:
      begin
        if (!power_request)
        begin
          next_state = ST_DOWN;
          next_slot = 4'h1;
        end
      end
      ST_DOWN:
      begin
        if (boost_stop == current_slot)
          next_boost_en = 1'b0;
        if (conv6_stop == current_slot)
          next_conv6_en = 1'b0;
        if (slot_end)
        begin
          if (current_slot == `DCSEQ_SLOT_LAST)
          begin
            next_state = ST_OFF;
            next_slot = 4'h0;
            next_boost_en = 1'b0;
            next_conv6_en = 1'b0;
          end
          else
            next_slot = current_slot + 4'h1;
        end
      end
      default:
      begin
        next_state = ST_OFF;
        next_slot = 4'h0;
      end
    endcase
    if (boost_fault_rise && boost_tmo[`DCSEQ_FAULT_ACT] == `DCSEQ_ACT_CONV)
      next_boost_en = 1'b0;
    if (conv6_fault_rise && conv6_tmo[`DCSEQ_FAULT_ACT] == `DCSEQ_ACT_CONV)
      next_conv6_en = 1'b0;
    if (sys_fault)
    begin
      next_state = ST_OFF;
      next_slot = 4'h0;
      next_boost_en = 1'b0;
      next_conv6_en = 1'b0;
    end
  end

  // interrupt events and register read mux
  always @*
  begin
    events = {next_state == ST_OFF && state == ST_DOWN,
      next_state == ST_ACTIVE && state == ST_UP,
      conv6_fault_rise, boost_fault_rise};
    wr_sel = reg_select(aw_addr);
    rd_sel = reg_select(s_axi_araddr);
    wr_value = 16'h0000;
    case (wr_sel)
      SEL_BC: wr_value = lane_merge(boost_ctrl, w_data, w_strb);
      SEL_BT: wr_value = lane_merge(boost_tmo, w_data, w_strb);
      SEL_CC: wr_value = lane_merge(conv6_ctrl, w_data, w_strb);
      SEL_CT: wr_value = lane_merge(conv6_tmo, w_data, w_strb);
      default: wr_value = 16'h0000;
    endcase
    case (rd_sel)
      SEL_BC: rd_value = boost_ctrl;
      SEL_BT: rd_value = boost_tmo;
      SEL_CC: rd_value = conv6_ctrl;
      SEL_CT: rd_value = conv6_tmo;
      SEL_IS: rd_value = {12'h000, irq_status};
      SEL_IM: rd_value = {12'h000, irq_mask};
      SEL_SS: rd_value = {4'h0, conv6_tripped, boost_tripped,
        conv6_enable, boost_enable, current_slot, state};
      default: rd_value = 16'h0000;
    endcase
    vcode_clamped = conv6_ctrl[`DCSEQ_VCODE];
    if (vcode_clamped > `DCSEQ_VCODE_MAX)
      vcode_clamped = `DCSEQ_VCODE_MAX;
  end

  // registers, sequencer and bus slave
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      boost_ctrl <= BOOST_CTRL_DEFAULT & `DCSEQ_MASK_BOOST_CTRL;
      boost_tmo <= BOOST_TMO_DEFAULT & `DCSEQ_MASK_TMO;
      conv6_ctrl <= CONV6_CTRL_DEFAULT & `DCSEQ_MASK_CONV6_CTRL;
      conv6_tmo <= CONV6_TMO_DEFAULT & `DCSEQ_MASK_TMO;
      irq_status <= 4'h0;
      irq_mask <= `DCSEQ_DEF_IRQ_MASK;
      state <= ST_OFF;
      current_slot <= 4'h0;
      slot_timer <= 24'h000000;
      boost_fault_q <= 1'b0;
      conv6_fault_q <= 1'b0;
      boost_tripped <= 1'b0;
      conv6_tripped <= 1'b0;
      boost_enable <= 1'b0;
      conv6_enable <= 1'b0;
      system_shutdown <= 1'b0;
      seq_active <= 1'b0;
      irq <= 1'b0;
      fb_external_divider <= 1'b0;
      fb_current_sink_a <= 1'b0;
      fb_current_sink_b <= 1'b0;
      fb_usb_divider <= 1'b0;
      conv6_output_capacitance <= 2'h0;
      conv6_overvoltage_enable <= 1'b0;
      conv6_discharge <= 1'b0;
      conv6_voltage_code <= 7'h00;
      conv6_voltage_mv <= 12'h000;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OK;
      s_axi_rdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      boost_fault_q <= boost_fault;
      conv6_fault_q <= conv6_fault;
      state <= next_state;
      current_slot <= next_slot;
      boost_enable <= next_boost_en;
      conv6_enable <= next_conv6_en;
      system_shutdown <= sys_fault;
      seq_active <= (next_state == ST_ACTIVE);
      if (next_slot != current_slot || next_state != state)
        slot_timer <= 24'h000000;
      else if (state == ST_UP || state == ST_DOWN)
        slot_timer <= slot_timer + 24'h000001;
      if (state == ST_OFF && next_state == ST_UP)
      begin
        boost_tripped <= 1'b0;
        conv6_tripped <= 1'b0;
      end
      if (boost_fault_rise && boost_tmo[`DCSEQ_FAULT_ACT] == `DCSEQ_ACT_CONV)
        boost_tripped <= 1'b1;
      if (conv6_fault_rise && conv6_tmo[`DCSEQ_FAULT_ACT] == `DCSEQ_ACT_CONV)
        conv6_tripped <= 1'b1;
      fb_external_divider <= boost_ctrl[`DCSEQ_FB_SRC] == `DCSEQ_FB_EXT;
      fb_current_sink_a <= boost_ctrl[`DCSEQ_FB_SRC] == `DCSEQ_FB_SINK_A;
      fb_current_sink_b <= boost_ctrl[`DCSEQ_FB_SRC] == `DCSEQ_FB_SINK_B;
      fb_usb_divider <= boost_ctrl[`DCSEQ_FB_SRC] == `DCSEQ_FB_USB;
      conv6_output_capacitance <= conv6_ctrl[`DCSEQ_CAP];
      conv6_overvoltage_enable <= ~conv6_ctrl[`DCSEQ_OVP_DIS];
      conv6_discharge <= ~next_conv6_en & ~conv6_ctrl[`DCSEQ_OUT_FLOAT];
      conv6_voltage_code <= vcode_clamped;
      conv6_voltage_mv <= `DCSEQ_MV_BASE
        + {5'h00, vcode_clamped} * `DCSEQ_MV_STEP;
      // write address and data are taken in either order
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_held & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == SEL_NONE || wr_sel == SEL_SS)
          ? RESP_ERR : RESP_OK;
        if (wr_sel == SEL_BC)
          boost_ctrl <= wr_value & `DCSEQ_MASK_BOOST_CTRL;
        if (wr_sel == SEL_BT)
          boost_tmo <= wr_value & `DCSEQ_MASK_TMO;
        if (wr_sel == SEL_CC)
          conv6_ctrl <= wr_value & `DCSEQ_MASK_CONV6_CTRL;
        if (wr_sel == SEL_CT)
          conv6_tmo <= wr_value & `DCSEQ_MASK_TMO;
        if (wr_sel == SEL_IM && w_strb[0])
          irq_mask <= w_data[3:0];
      end
      // sticky status, a new event wins over a write-one clear
      if (do_write && wr_sel == SEL_IS && w_strb[0])
        irq_status <= (irq_status & ~w_data[3:0]) | events;
      else
        irq_status <= irq_status | events;
      irq <= |(irq_status & ~irq_mask);
      if (sys_fault)
      begin
        boost_ctrl <= BOOST_CTRL_DEFAULT & `DCSEQ_MASK_BOOST_CTRL;
        boost_tmo <= BOOST_TMO_DEFAULT & `DCSEQ_MASK_TMO;
        conv6_ctrl <= CONV6_CTRL_DEFAULT & `DCSEQ_MASK_CONV6_CTRL;
        conv6_tmo <= CONV6_TMO_DEFAULT & `DCSEQ_MASK_TMO;
      end
      // read channel, one read at a time
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_value};
        s_axi_rresp <= (rd_sel == SEL_NONE) ? RESP_ERR : RESP_OK;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

endmodule

// file: verification/dcseq_chk.sv
// checker for the converter sequencer outputs
`timescale 1ns/10ps
module dcseq_chk (
  input wire core_clk,
  input wire reset,
  input wire fb_external_divider,
  input wire fb_current_sink_a,
  input wire fb_current_sink_b,
  input wire fb_usb_divider,
  input wire boost_enable,
  input wire conv6_enable,
  input wire conv6_discharge,
  input wire [6:0] conv6_voltage_code,
  input wire [11:0] conv6_voltage_mv,
  input wire system_shutdown,
  input wire [3:0] current_slot,
  input wire seq_active,
  input wire irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  fb_onehot_a: assert property (!$past(reset) && !$past(reset, 2) |->
    $onehot({fb_usb_divider, fb_current_sink_b, fb_current_sink_a,
    fb_external_divider})) else $error("feedback select not one-hot");
  volt_formula_a: assert property (!$past(reset) |->
    conv6_voltage_mv == 12'h352 + 12'h019 * conv6_voltage_code)
    else $error("voltage in mv does not match code");
  volt_max_a: assert property (conv6_voltage_code <= 7'h66)
    else $error("voltage code above maximum");
  slot_range_a: assert property (current_slot <= 4'he)
    else $error("slot number above fourteen");
  slot_step_a: assert property ($changed(current_slot) &&
    current_slot != 4'h0 |-> current_slot == $past(current_slot) + 4'h1)
    else $error("slot did not ascend by one");
  active_entry_a: assert property ($rose(seq_active) |->
    $past(current_slot) == 4'he) else $error("active not after slot 14");
  active_slot_a: assert property (seq_active |-> current_slot == 4'h0)
    else $error("slot nonzero while active");
  discharge_off_a: assert property (conv6_discharge |-> !conv6_enable)
    else $error("discharge while converter on");
  shutdown_pulse_a: assert property (system_shutdown |=>
    !system_shutdown && !boost_enable && !conv6_enable && !seq_active)
    else $error("system shutdown left converters on");
  reset_off_a: assert property (disable iff (1'b0) reset |=>
    !boost_enable && !conv6_enable && !seq_active)
    else $error("converters on after reset");
  cover property ($rose(seq_active));
  cover property (system_shutdown);
  cover property ($rose(irq));
endmodule
bind dcseq_top dcseq_chk chk_u (
  .core_clk(core_clk), .reset(reset),
  .fb_external_divider(fb_external_divider),
  .fb_current_sink_a(fb_current_sink_a),
  .fb_current_sink_b(fb_current_sink_b), .fb_usb_divider(fb_usb_divider),
  .boost_enable(boost_enable), .conv6_enable(conv6_enable),
  .conv6_discharge(conv6_discharge), .conv6_voltage_code(conv6_voltage_code),
  .conv6_voltage_mv(conv6_voltage_mv), .system_shutdown(system_shutdown),
  .current_slot(current_slot), .seq_active(seq_active), .irq(irq));

// file: verification/tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
module tb;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg clk_en = 1'b1;
  reg sd_seen = 1'b0;
  reg power_request = 1'b0;
  reg boost_fault = 1'b0;
  reg conv6_fault = 1'b0;
  reg [11:0] s_axi_awaddr = 12'h000;
  reg s_axi_awvalid = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg [11:0] s_axi_araddr = 12'h000;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  wire awrdy, wrdy, bvld, arrdy, rvld, b_en, c_en, ovp, dis, sd, act, irq;
  wire fb0, fb1, fb2, fb3;
  wire [1:0] bresp, rresp, cap;
  wire [31:0] rdata;
  wire [6:0] code;
  wire [11:0] mv;
  wire [3:0] slot;
  integer failures = 0;
  integer cmp_count = 0;
  integer i;
  reg [31:0] rd;
  reg [1:0] rs;
  reg [15:0] v;
  reg [6:0] c;
  dcseq_top #(.SLOT_CYCLES(24'h000004)) dut_u (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .power_request(power_request), .boost_fault(boost_fault),
    .conv6_fault(conv6_fault), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awrdy),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvld), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvld), .s_axi_rready(s_axi_rready), .boost_enable(b_en),
    .fb_external_divider(fb0), .fb_current_sink_a(fb1),
    .fb_current_sink_b(fb2), .fb_usb_divider(fb3), .conv6_enable(c_en),
    .conv6_output_capacitance(cap), .conv6_overvoltage_enable(ovp),
    .conv6_discharge(dis), .conv6_voltage_code(code),
    .conv6_voltage_mv(mv), .system_shutdown(sd), .current_slot(slot),
    .seq_active(act), .irq(irq));
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  // catch the one-cycle shutdown pulse
  always @(posedge core_clk)
  begin
    if (sd === 1'b1)
      sd_seen <= 1'b1;
  end
  task report_and_stop;
    begin
      if (failures == 0 && cmp_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task hang;
    begin
      failures = failures + 1;
      report_and_stop;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task wr(input [11:0] a, input [15:0] d);
    integer n;
    reg done;
    begin
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      done = 1'b0;
      while (!done && n < 100)
      begin
        @(posedge core_clk);
        n = n + 1;
        if (s_axi_awvalid && awrdy === 1'b1)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && wrdy === 1'b1)
          s_axi_wvalid <= 1'b0;
        done = (bvld === 1'b1);
      end
      rs = bresp;
      s_axi_bready <= 1'b0;
      if (!done)
        hang;
    end
  endtask
  task rdr(input [11:0] a);
    integer n;
    reg done;
    begin
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      done = 1'b0;
      while (!done && n < 100)
      begin
        @(posedge core_clk);
        n = n + 1;
        if (s_axi_arvalid && arrdy === 1'b1)
          s_axi_arvalid <= 1'b0;
        done = (rvld === 1'b1);
      end
      rd = rdata;
      rs = rresp;
      s_axi_rready <= 1'b0;
      if (!done)
        hang;
    end
  endtask
  task wslot(input [3:0] s);
    integer n;
    begin
      for (n = 0; n < 300 && slot !== s; n = n + 1)
        @(posedge core_clk);
      if (slot !== s)
        hang;
    end
  endtask
  task wact;
    integer n;
    begin
      for (n = 0; n < 300 && act !== 1'b1; n = n + 1)
        @(posedge core_clk);
      if (act !== 1'b1)
        hang;
    end
  endtask
  task trip(input sel);
    begin
      if (sel)
        conv6_fault <= 1'b1;
      else
        boost_fault <= 1'b1;
      cyc(2);
      conv6_fault <= 1'b0;
      boost_fault <= 1'b0;
      cyc(3);
    end
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    cyc(3);
    chk("fb ext", fb0, 32'h1);
    rdr(12'h300);
    chk("boost ctrl", rd, 32'h8);
    rdr(12'h304);
    chk("boost tmo", rd, 32'h0);
    rdr(12'h30c);
    chk("c6 ctrl", rd, 32'h0);
    rdr(12'h324);
    chk("irq mask", rd, 32'hf);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(12'h300, {14'h0002, i[1:0]});
      cyc(3);
      chk("fb sel", {fb3, fb2, fb1, fb0}, 32'h1 << i);
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      v = (i == 0) ? 16'hc866 : (i == 1) ? 16'h4470 : 16'h8000;
      wr(12'h30c, v);
      cyc(3);
      c = (v[6:0] > 7'h66) ? 7'h66 : v[6:0];
      chk("c6 cap", cap, v[15:14]);
      chk("c6 ovp", ovp, {31'h0, ~v[11]});
      chk("c6 dis", dis, {31'h0, ~v[10]});
      chk("c6 code", code, c);
      chk("c6 mv", mv, 12'h352 + 12'h019 * c);
    end
    wr(12'h304, 16'h0d40);
    wr(12'h310, 16'h7c00);
    power_request <= 1'b1;
    wslot(4'h2);
    cyc(2);
    chk("b early", b_en, 32'h0);
    wslot(4'h3);
    cyc(2);
    chk("b start", b_en, 32'h1);
    chk("c6 early", c_en, 32'h0);
    wact;
    cyc(2);
    chk("c6 start", c_en, 32'h1);
    chk("act slot", slot, 32'h0);
    rdr(12'h320);
    chk("st act", rd, 32'h4);
    chk("irq mskd", irq, 32'h0);
    wr(12'h324, 16'h0000);
    cyc(3);
    chk("irq on", irq, 32'h1);
    wr(12'h320, 16'h0004);
    cyc(3);
    chk("irq clr", irq, 32'h0);
    trip(1'b0);
    chk("b ignore", b_en, 32'h1);
    chk("irq fault", irq, 32'h1);
    rdr(12'h320);
    chk("st boost", rd, 32'h1);
    wr(12'h320, 16'h0001);
    power_request <= 1'b0;
    wslot(4'h4);
    clk_en <= 1'b0;
    cyc(10);
    chk("freeze", slot, 32'h4);
    clk_en <= 1'b1;
    cyc(2);
    chk("b hold", b_en, 32'h1);
    wslot(4'h5);
    cyc(2);
    chk("b stop", b_en, 32'h0);
    chk("c6 hold", c_en, 32'h1);
    wslot(4'he);
    wslot(4'h0);
    cyc(2);
    chk("c6 stop", c_en, 32'h0);
    rdr(12'h320);
    chk("st off", rd, 32'h8);
    wr(12'h320, 16'h000f);
    wr(12'h304, 16'h8d40);
    power_request <= 1'b1;
    wact;
    cyc(2);
    trip(1'b1);
    chk("c6 trip", c_en, 32'h0);
    chk("b keep", b_en, 32'h1);
    chk("c6 no sys", sd_seen, 32'h0);
    trip(1'b0);
    chk("sys off", {b_en, c_en, act}, 32'h0);
    chk("sys pulse", sd_seen, 32'h1);
    rdr(12'h304);
    chk("reload", rd, 32'h0);
    rdr(12'h320);
    chk("st both", rd, 32'h7);
    power_request <= 1'b0;
    rdr(12'h000);
    chk("unm resp", rs, 32'h2);
    chk("unm data", rd, 32'h0);
    wr(12'h328, 16'h0001);
    chk("ro resp", rs, 32'h2);
    report_and_stop;
  end
endmodule
